// ---- hw/edp_policy.sv ----
// enclave debug and exception policy with apb register slave
`timescale 1ns/1ps
`include "edp_consts.svh"

module edp_policy (
    input  logic                clock_in,
    input  logic                rst_b_in,
    // apb slave
    input  logic                psel_in,
    input  logic                penable_in,
    input  logic                pwrite_in,
    input  logic [7:0]          paddr_in,
    input  logic [31:0]         pwdata_in,
    output logic [31:0]         prdata_out,
    output logic                pready_out,
    output logic                pslverr_out,
    // core event port
    input  logic                evt_valid_in,
    input  edp_pkg::edp_evt_t   evt_kind_in,
    input  logic                in_enclave_in,
    input  logic                in_elided_in,
    input  logic                in_txn_in,
    input  logic                handler_inside_in,
    input  logic                fault_in,
    input  logic                vm_exit_in,
    input  logic                guest_in,
    input  logic                mon_ctl_in,
    input  logic                step_flag_in,
    input  logic                step_masked_in,
    input  logic                mon_masked_in,
    input  logic                opt_in_flag_in,
    input  logic                debug_attr_in,
    input  logic [1:0]          priv_in,
    input  logic [1:0]          io_priv_in,
    input  logic                v86_in,
    input  logic                virq_en_in,
    input  logic                virq_pend_in,
    input  logic                virq_flag_in,
    // verdict
    output logic                act_valid_out,
    output edp_pkg::edp_act_t   act_out,
    output logic                rip_to_begin_out,
    output logic                gp_ip_fallback_out,
    output logic                dbgstat_b16_clr_out,
    output logic                pend_b16_set_out,
    output logic                ss_pend_out,
    output logic                mon_pend_out,
    output logic                virq_pend_out,
    output logic                virq_flag_out,
    output logic                saved_virq_pend_out,
    output logic                saved_virq_flag_out,
    output logic                opt_in_out,
    output logic                feature_cap_out
);

    logic                       dbgctl_b11_r;
    logic                       featctl_b15_r;
    logic [`EDP_NUM_BANKS-1:0]  bank_en_r;
    logic                       feat_on_r;
    logic                       cap_lost_r;
    logic                       opt_in_r;
    logic                       apb_wr;
    logic                       apb_rd;
    logic                       txn_encl;
    logic                       dbg_live;
    logic                       mon_arm;
    logic                       exit_nxt;
    logic                       bank_drop;
    logic [31:0]                rd_nxt;
    edp_pkg::edp_act_t          act_nxt;
    logic                       ss_nxt;
    logic                       mon_nxt;
    logic                       rip_nxt;
    logic                       gpip_nxt;
    logic                       clr16_nxt;
    logic                       pend16_nxt;

    // true for an address that holds a register
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == `EDP_OFS_DBGCTL) || (a == `EDP_OFS_FEATCTL) ||
                  (a == `EDP_OFS_MCBANK) || (a == `EDP_OFS_CTRL) ||
                  (a == `EDP_OFS_STATUS);
    endfunction

    // one wait state: pready rises in the second access cycle
    assign apb_wr = psel_in & penable_in & pready_out & pwrite_in;
    assign apb_rd = psel_in & penable_in & ~pready_out & ~pwrite_in;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= psel_in & penable_in & ~pready_out;
            pslverr_out <= psel_in & penable_in & ~pready_out & ~reg_hit(paddr_in);
        end
    end

    // read data mux; status shows live capability and entry kind
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (paddr_in)
            `EDP_OFS_DBGCTL:  rd_nxt[`EDP_DBGCTL_TXN_BIT] = dbgctl_b11_r;
            `EDP_OFS_FEATCTL: rd_nxt[`EDP_FEATCTL_TXN_BIT] = featctl_b15_r;
            `EDP_OFS_MCBANK:  rd_nxt[`EDP_NUM_BANKS-1:0] = bank_en_r;
            `EDP_OFS_CTRL:    rd_nxt[`EDP_CTRL_FEAT_BIT] = feat_on_r;
            `EDP_OFS_STATUS: begin
                rd_nxt[`EDP_STAT_CAP_BIT]   = feature_cap_out;
                rd_nxt[`EDP_STAT_OPTIN_BIT] = opt_in_r;
                rd_nxt[`EDP_STAT_LOST_BIT]  = cap_lost_r;
            end
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (apb_rd) begin
            prdata_out <= rd_nxt;
        end
    end

    // software-written controls; writes land at the edge pready is sampled
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dbgctl_b11_r  <= 1'b0;
            featctl_b15_r <= 1'b0;
            bank_en_r     <= `EDP_BANK_RESET;
            feat_on_r     <= 1'b0;
        end else if (apb_wr) begin
            case (paddr_in)
                `EDP_OFS_DBGCTL:  dbgctl_b11_r <= pwdata_in[`EDP_DBGCTL_TXN_BIT];
                `EDP_OFS_FEATCTL: featctl_b15_r <= pwdata_in[`EDP_FEATCTL_TXN_BIT];
                `EDP_OFS_MCBANK:  bank_en_r <= pwdata_in[`EDP_NUM_BANKS-1:0];
                `EDP_OFS_CTRL:    feat_on_r <= pwdata_in[`EDP_CTRL_FEAT_BIT];
                default:          feat_on_r <= feat_on_r;
            endcase
        end
    end

    // a supported bank going from one to zero is a one-way loss
    assign bank_drop = apb_wr && (paddr_in == `EDP_OFS_MCBANK) &&
                       |(bank_en_r & ~pwdata_in[`EDP_NUM_BANKS-1:0] & `EDP_BANK_SUPPORTED);

    // sticky loss; only reset clears it, so no set/clear race exists
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cap_lost_r <= 1'b0;
        end else if (bank_drop) begin
            cap_lost_r <= 1'b1;
        end else if (evt_valid_in && evt_kind_in == edp_pkg::EVT_MC_FAULT && feat_on_r) begin
            cap_lost_r <= 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            feature_cap_out <= 1'b0;
        end else begin
            feature_cap_out <= feat_on_r & ~cap_lost_r &
                               (&(bank_en_r | ~`EDP_BANK_SUPPORTED));
        end
    end

    assign txn_encl = in_enclave_in & in_txn_in;
    assign dbg_live = opt_in_r & dbgctl_b11_r & featctl_b15_r;
    assign mon_arm  = guest_in & mon_ctl_in;

    // verdict for the presented event
    always_comb begin
        act_nxt    = edp_pkg::ACT_NONE;
        ss_nxt     = 1'b0;
        mon_nxt    = 1'b0;
        rip_nxt    = 1'b0;
        gpip_nxt   = 1'b0;
        clr16_nxt  = 1'b0;
        pend16_nxt = 1'b0;
        case (evt_kind_in)
            edp_pkg::EVT_OP_USER, edp_pkg::EVT_OP_SUPER: begin
                if (in_txn_in) begin
                    act_nxt = edp_pkg::ACT_ABORT_FB;
                end else if (in_elided_in) begin
                    act_nxt = edp_pkg::ACT_ABORT_RETRY;
                end else if (evt_kind_in == edp_pkg::EVT_OP_SUPER) begin
                    ss_nxt  = step_flag_in & ~fault_in;
                    mon_nxt = mon_arm & (~fault_in | ~vm_exit_in);
                end
            end
            edp_pkg::EVT_REPORT, edp_pkg::EVT_KEY_REQ: begin
                ss_nxt  = step_flag_in & ~step_masked_in & ~fault_in;
                mon_nxt = mon_arm & ~mon_masked_in &
                          (~fault_in | ~vm_exit_in);
            end
            // handler location is deliberately not looked at
            edp_pkg::EVT_TXN_BEGIN: act_nxt = edp_pkg::ACT_NONE;
            edp_pkg::EVT_FETCH_OUT, edp_pkg::EVT_PAGE_DENY: begin
                if (txn_encl) begin
                    act_nxt = edp_pkg::ACT_ABORT_FB;
                end
            end
            edp_pkg::EVT_TXN_ABORT: begin
                if (txn_encl && !handler_inside_in) begin
                    act_nxt  = edp_pkg::ACT_GP_FAULT;
                    gpip_nxt = 1'b1;
                end else if (txn_encl) begin
                    act_nxt = edp_pkg::ACT_ABORT_FB;
                end
            end
            edp_pkg::EVT_DBG_FAULT, edp_pkg::EVT_BP_FAULT: begin
                if (txn_encl && dbg_live) begin
                    // breakpoint is converted to debug fault
                    act_nxt    = edp_pkg::ACT_DBG_EXIT;
                    rip_nxt    = 1'b1;
                    clr16_nxt  = ~vm_exit_in;
                    pend16_nxt = vm_exit_in;
                end else if (txn_encl) begin
                    act_nxt = edp_pkg::ACT_ABORT_FB;
                end
            end
            edp_pkg::EVT_MC_FAULT, edp_pkg::EVT_CORR_MC: begin
                if (in_enclave_in) begin
                    act_nxt = edp_pkg::ACT_MC_EXIT;
                end
            end
            edp_pkg::EVT_SET_IRQ: begin
                if (io_priv_in == `EDP_IO_PRIV_TOP) begin
                    act_nxt = edp_pkg::ACT_SET_IF;
                end else if (virq_en_in && priv_in == `EDP_PRIV_USER && !v86_in &&
                             virq_pend_in && !virq_flag_in) begin
                    act_nxt = edp_pkg::ACT_GP_FAULT;
                end
            end
            edp_pkg::EVT_DBG_READ, edp_pkg::EVT_DBG_WRITE: begin
                // production enclaves are never opened
                act_nxt = debug_attr_in ? edp_pkg::ACT_GRANT : edp_pkg::ACT_REFUSE;
            end
            edp_pkg::EVT_PAGE_ADD: act_nxt = edp_pkg::ACT_FLAG_CLEAR;
            default: act_nxt = edp_pkg::ACT_NONE;
        endcase
    end

    // verdict outputs stand for exactly one cycle after the event
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            act_valid_out       <= 1'b0;
            act_out             <= edp_pkg::ACT_NONE;
            ss_pend_out         <= 1'b0;
            mon_pend_out        <= 1'b0;
            rip_to_begin_out    <= 1'b0;
            gp_ip_fallback_out  <= 1'b0;
            dbgstat_b16_clr_out <= 1'b0;
            pend_b16_set_out    <= 1'b0;
        end else begin
            act_valid_out       <= evt_valid_in;
            act_out             <= evt_valid_in ? act_nxt : edp_pkg::ACT_NONE;
            ss_pend_out         <= evt_valid_in & ss_nxt;
            mon_pend_out        <= evt_valid_in & mon_nxt;
            rip_to_begin_out    <= evt_valid_in & rip_nxt;
            gp_ip_fallback_out  <= evt_valid_in & gpip_nxt;
            dbgstat_b16_clr_out <= evt_valid_in & clr16_nxt;
            pend_b16_set_out    <= evt_valid_in & pend16_nxt;
        end
    end

    // any leave of the enclave, architectural or forced
    assign exit_nxt = evt_valid_in &&
                      (evt_kind_in == edp_pkg::EVT_EXIT || evt_kind_in == edp_pkg::EVT_FEXIT ||
                       act_nxt == edp_pkg::ACT_DBG_EXIT || act_nxt == edp_pkg::ACT_MC_EXIT);

    // entry kind tracking; an exit in the same cycle as nothing else
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            opt_in_r <= 1'b0;
        end else if (evt_valid_in && (evt_kind_in == edp_pkg::EVT_ENTER ||
                                      evt_kind_in == edp_pkg::EVT_RESUME)) begin
            opt_in_r <= opt_in_flag_in;
        end else if (exit_nxt) begin
            opt_in_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            opt_in_out <= 1'b0;
        end else begin
            opt_in_out <= opt_in_r;
        end
    end

    // virtual irq bits pass through untouched on entry, resume and exit
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            virq_pend_out <= 1'b0;
            virq_flag_out <= 1'b0;
        end else if (evt_valid_in && (evt_kind_in == edp_pkg::EVT_ENTER ||
                                      evt_kind_in == edp_pkg::EVT_RESUME ||
                                      exit_nxt)) begin
            virq_pend_out <= virq_pend_in;
            virq_flag_out <= virq_flag_in;
        end
    end

    // image saved on forced exit; the image is never read back into the flags
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            saved_virq_pend_out <= 1'b0;
            saved_virq_flag_out <= 1'b0;
        end else if (exit_nxt && evt_kind_in != edp_pkg::EVT_EXIT) begin
            saved_virq_pend_out <= virq_pend_in;
            saved_virq_flag_out <= virq_flag_in;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);

    a_elided_retry: assert property (
        evt_valid_in && evt_kind_in == edp_pkg::EVT_OP_USER && !in_txn_in && in_elided_in
        |=> act_out == edp_pkg::ACT_ABORT_RETRY)
        else $error("elided region op not retried");
    a_fetch_no_gp: assert property (
        evt_valid_in && evt_kind_in == edp_pkg::EVT_FETCH_OUT && in_enclave_in && in_txn_in
        |=> act_out == edp_pkg::ACT_ABORT_FB)
        else $error("outside fetch did not abort to fallback");
    a_abort_gp_ip: assert property (
        evt_valid_in && evt_kind_in == edp_pkg::EVT_TXN_ABORT && in_enclave_in &&
        in_txn_in && !handler_inside_in
        |=> act_out == edp_pkg::ACT_GP_FAULT && gp_ip_fallback_out)
        else $error("outside fallback did not fault");
    a_optout_dbg: assert property (
        evt_valid_in && evt_kind_in == edp_pkg::EVT_DBG_FAULT && in_enclave_in &&
        in_txn_in && !opt_in_out && !$past(evt_valid_in)
        |=> act_out == edp_pkg::ACT_ABORT_FB && !rip_to_begin_out)
        else $error("opt-out debug fault delivered");
    a_dbg_deliver: assert property (
        act_out == edp_pkg::ACT_DBG_EXIT |-> rip_to_begin_out ##1 !opt_in_out)
        else $error("debug delivery without rewind or exit");
    a_b16_exclusive: assert property (
        rip_to_begin_out |-> (dbgstat_b16_clr_out ^ pend_b16_set_out))
        else $error("status bit 16 handling wrong");
    a_mc_cap_lost: assert property (
        evt_valid_in && evt_kind_in == edp_pkg::EVT_MC_FAULT && feat_on_r
        |=> ##1 !feature_cap_out [*4])
        else $error("capability survived machine check");
    a_set_irq_fault: assert property (
        evt_valid_in && evt_kind_in == edp_pkg::EVT_SET_IRQ && io_priv_in != `EDP_IO_PRIV_TOP &&
        virq_en_in && priv_in == `EDP_PRIV_USER && !v86_in && virq_pend_in && !virq_flag_in
        |=> act_out == edp_pkg::ACT_GP_FAULT)
        else $error("set-irq did not fault");
    a_dbg_refuse: assert property (
        evt_valid_in && evt_kind_in == edp_pkg::EVT_DBG_READ && !debug_attr_in
        |=> act_out == edp_pkg::ACT_REFUSE)
        else $error("production enclave opened");
    a_fault_no_ss: assert property (
        evt_valid_in && evt_kind_in == edp_pkg::EVT_OP_SUPER && fault_in
        |=> !ss_pend_out)
        else $error("single step after fault");
    a_entry_kind: assert property (
        evt_valid_in && evt_kind_in == edp_pkg::EVT_ENTER
        |=> ##1 opt_in_out == $past(opt_in_flag_in, 2))
        else $error("entry kind not tracked");

    c_dbg_exit: cover property (act_out == edp_pkg::ACT_DBG_EXIT);
    c_mc_exit:  cover property (act_out == edp_pkg::ACT_MC_EXIT ##1 !opt_in_out);
    c_gp_abort: cover property (act_out == edp_pkg::ACT_GP_FAULT && gp_ip_fallback_out);

endmodule

// ---- hw/edp_consts.svh ----
// register offsets, field positions and reset values of the enclave debug policy block
`ifndef EDP_CONSTS_SVH
`define EDP_CONSTS_SVH

`define EDP_OFS_DBGCTL      8'h00
`define EDP_OFS_FEATCTL     8'h04
`define EDP_OFS_MCBANK      8'h08
`define EDP_OFS_CTRL        8'h0c
`define EDP_OFS_STATUS      8'h10

`define EDP_DBGCTL_TXN_BIT  11
`define EDP_FEATCTL_TXN_BIT 15
`define EDP_DBGSTAT_TXN_BIT 16
`define EDP_CTRL_FEAT_BIT   0
`define EDP_STAT_CAP_BIT    0
`define EDP_STAT_OPTIN_BIT  1
`define EDP_STAT_LOST_BIT   2

`define EDP_NUM_BANKS       8
`define EDP_BANK_SUPPORTED  8'hff
`define EDP_BANK_RESET      8'hff
`define EDP_IO_PRIV_TOP     2'h3
`define EDP_PRIV_USER       2'h3

`endif

// ---- hw/edp_pkg.sv ----
// types shared by the enclave debug policy block
package edp_pkg;

    // core events presented on the event port
    typedef enum logic [4:0] {
        EVT_OP_USER   = 5'h00,
        EVT_OP_SUPER  = 5'h01,
        EVT_TXN_BEGIN = 5'h02,
        EVT_FETCH_OUT = 5'h03,
        EVT_PAGE_DENY = 5'h04,
        EVT_TXN_ABORT = 5'h05,
        EVT_DBG_FAULT = 5'h06,
        EVT_BP_FAULT  = 5'h07,
        EVT_MC_FAULT  = 5'h08,
        EVT_CORR_MC   = 5'h09,
        EVT_ENTER     = 5'h0a,
        EVT_RESUME    = 5'h0b,
        EVT_EXIT      = 5'h0c,
        EVT_FEXIT     = 5'h0d,
        EVT_SET_IRQ   = 5'h0e,
        EVT_REPORT    = 5'h0f,
        EVT_KEY_REQ   = 5'h10,
        EVT_DBG_READ  = 5'h11,
        EVT_DBG_WRITE = 5'h12,
        EVT_PAGE_ADD  = 5'h13
    } edp_evt_t;

    // verdict handed back to the core
    typedef enum logic [3:0] {
        ACT_NONE        = 4'h0,
        ACT_ABORT_RETRY = 4'h1,
        ACT_ABORT_FB    = 4'h2,
        ACT_GP_FAULT    = 4'h3,
        ACT_DBG_EXIT    = 4'h4,
        ACT_MC_EXIT     = 4'h5,
        ACT_GRANT       = 4'h6,
        ACT_REFUSE      = 4'h7,
        ACT_FLAG_CLEAR  = 4'h8,
        ACT_SET_IF      = 4'h9
    } edp_act_t;

endpackage

// ---- dv/enclave_debug_exception_policy_test.sv ----
// self-checking bench for the enclave debug and exception policy block
`timescale 1ns/1ps
`include "edp_consts.svh"

module enclave_debug_exception_policy_test;
    // context bits in port order except priv_in and io_priv_in, which sit at the bottom; enclave flag at the top
    localparam logic [20:0] c_enc = 21'h100000, c_eld = 21'h080000, c_txn = 21'h040000,
        c_hin = 21'h020000, c_flt = 21'h010000, c_vmx = 21'h008000, c_gst = 21'h004000,
        c_mtc = 21'h002000, c_tr = 21'h001000, c_trm = 21'h000800, c_mtm = 21'h000400,
        c_opt = 21'h000200, c_dba = 21'h000100, c_v86 = 21'h000080, c_ven = 21'h000040,
        c_vpn = 21'h000020, c_vfl = 21'h000010, c_pl3 = 21'h00000c, c_io3 = 21'h000003,
        c_etx = 21'h140000, c_tmg = 21'h007000, c_irq = 21'h00006c;
    logic              clock_in = 1'b0;
    logic              rst_b = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, evt_valid = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0, prdata;
    logic [20:0]       ctx = 21'h0;
    edp_pkg::edp_evt_t evt_kind = edp_pkg::EVT_OP_USER;
    edp_pkg::edp_act_t act;
    logic              pready, pslverr, act_valid, rip_b, gp_fb, clr16, pend16, ss, mon;
    logic              vpn, vfl, svpn, svfl, optin, cap;
    int                mismatches = 0;
    int                checks_done = 0;

    // 4 ns period
    always #2 clock_in = ~clock_in;

    edp_policy u_edp_policy (
        .clock_in(clock_in), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .evt_valid_in(evt_valid),
        .evt_kind_in(evt_kind), .in_enclave_in(ctx[20]), .in_elided_in(ctx[19]),
        .in_txn_in(ctx[18]), .handler_inside_in(ctx[17]), .fault_in(ctx[16]),
        .vm_exit_in(ctx[15]), .guest_in(ctx[14]), .mon_ctl_in(ctx[13]),
        .step_flag_in(ctx[12]), .step_masked_in(ctx[11]), .mon_masked_in(ctx[10]),
        .opt_in_flag_in(ctx[9]), .debug_attr_in(ctx[8]), .v86_in(ctx[7]),
        .virq_en_in(ctx[6]), .virq_pend_in(ctx[5]), .virq_flag_in(ctx[4]),
        .priv_in(ctx[3:2]), .io_priv_in(ctx[1:0]), .act_valid_out(act_valid),
        .act_out(act), .rip_to_begin_out(rip_b), .gp_ip_fallback_out(gp_fb),
        .dbgstat_b16_clr_out(clr16), .pend_b16_set_out(pend16), .ss_pend_out(ss),
        .mon_pend_out(mon), .virq_pend_out(vpn), .virq_flag_out(vfl),
        .saved_virq_pend_out(svpn), .saved_virq_flag_out(svfl), .opt_in_out(optin),
        .feature_cap_out(cap));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one apb transfer; pready is read as sampled at the edge, so release lands on that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        int n;
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            end_of_test();
        end
        if (!w) check(prdata, exp);
        check({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask

    // one event pulse; verdict and pulses {rip,gp,clr16,pend16,ss,mtf} one cycle later
    task automatic fire(input edp_pkg::edp_evt_t k, input logic [20:0] c,
                        input edp_pkg::edp_act_t a, input logic [5:0] f);
        @(posedge clock_in);
        evt_valid <= 1'b1;
        evt_kind <= k;
        ctx <= c;
        @(posedge clock_in);
        evt_valid <= 1'b0;
        #1;
        check({31'h0, act_valid}, 32'h1);
        check({28'h0, act}, {28'h0, a});
        check({26'h0, rip_b, gp_fb, clr16, pend16, ss, mon}, {26'h0, f});
    endtask

    // lets the lagging level outputs catch up
    task automatic settle;
        @(posedge clock_in);
        #1;
    endtask

    task automatic reset_dut;
        @(posedge clock_in);
        rst_b <= 1'b0;
        repeat (3) @(posedge clock_in);
        rst_b <= 1'b1;
    endtask

    // main sequence: registers, transaction verdicts, debug, flags, traps, machine checks
    initial begin
        reset_dut();
        check({31'h0, cap}, 32'h0);
        rd(`EDP_OFS_MCBANK, 32'hff);
        apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h14, 32'hffffffff, 32'h0, 1'b1);
        wr(`EDP_OFS_CTRL, 32'h1);
        rd(`EDP_OFS_STATUS, 32'h1);
        fire(edp_pkg::EVT_OP_USER, c_enc | c_eld, edp_pkg::ACT_ABORT_RETRY, 6'h00);
        fire(edp_pkg::EVT_OP_SUPER, c_enc | c_txn, edp_pkg::ACT_ABORT_FB, 6'h00);
        fire(edp_pkg::EVT_TXN_BEGIN, c_enc | c_txn, edp_pkg::ACT_NONE, 6'h00);
        fire(edp_pkg::EVT_FETCH_OUT, c_enc | c_txn, edp_pkg::ACT_ABORT_FB, 6'h00);
        fire(edp_pkg::EVT_PAGE_DENY, c_enc | c_txn, edp_pkg::ACT_ABORT_FB, 6'h00);
        fire(edp_pkg::EVT_TXN_ABORT, c_enc | c_txn, edp_pkg::ACT_GP_FAULT, 6'h10);
        fire(edp_pkg::EVT_TXN_ABORT, c_etx | c_hin, edp_pkg::ACT_ABORT_FB, 6'h00);
        wr(`EDP_OFS_DBGCTL, 32'h800);
        wr(`EDP_OFS_FEATCTL, 32'h8000);
        fire(edp_pkg::EVT_ENTER, c_enc, edp_pkg::ACT_NONE, 6'h00);
        fire(edp_pkg::EVT_DBG_FAULT, c_enc | c_txn, edp_pkg::ACT_ABORT_FB, 6'h00);
        fire(edp_pkg::EVT_ENTER, c_enc | c_opt, edp_pkg::ACT_NONE, 6'h00);
        settle();
        check({31'h0, optin}, 32'h1);
        fire(edp_pkg::EVT_DBG_FAULT, c_enc | c_txn, edp_pkg::ACT_DBG_EXIT, 6'h28);
        fire(edp_pkg::EVT_ENTER, c_enc | c_opt, edp_pkg::ACT_NONE, 6'h00);
        fire(edp_pkg::EVT_BP_FAULT, c_etx | c_vmx, edp_pkg::ACT_DBG_EXIT, 6'h24);
        wr(`EDP_OFS_DBGCTL, 32'h0);
        fire(edp_pkg::EVT_ENTER, c_enc | c_opt, edp_pkg::ACT_NONE, 6'h00);
        fire(edp_pkg::EVT_BP_FAULT, c_enc | c_txn, edp_pkg::ACT_ABORT_FB, 6'h00);
        wr(`EDP_OFS_DBGCTL, 32'h800);
        wr(`EDP_OFS_FEATCTL, 32'h0);
        fire(edp_pkg::EVT_DBG_FAULT, c_enc | c_txn, edp_pkg::ACT_ABORT_FB, 6'h00);
        fire(edp_pkg::EVT_ENTER, c_enc | c_vpn, edp_pkg::ACT_NONE, 6'h00);
        check({30'h0, vpn, vfl}, 32'h2);
        fire(edp_pkg::EVT_RESUME, c_enc | c_vfl, edp_pkg::ACT_NONE, 6'h00);
        check({30'h0, vpn, vfl}, 32'h1);
        fire(edp_pkg::EVT_FEXIT, c_enc | c_vpn | c_vfl, edp_pkg::ACT_NONE, 6'h00);
        check({28'h0, svpn, svfl, vpn, vfl}, 32'hf);
        fire(edp_pkg::EVT_EXIT, c_enc, edp_pkg::ACT_NONE, 6'h00);
        settle();
        check({29'h0, svpn, svfl, optin}, 32'h6);
        fire(edp_pkg::EVT_SET_IRQ, c_irq, edp_pkg::ACT_GP_FAULT, 6'h00);
        fire(edp_pkg::EVT_SET_IRQ, c_irq | c_io3, edp_pkg::ACT_SET_IF, 6'h00);
        fire(edp_pkg::EVT_SET_IRQ, c_irq | c_v86, edp_pkg::ACT_NONE, 6'h00);
        fire(edp_pkg::EVT_DBG_READ, c_dba, edp_pkg::ACT_GRANT, 6'h00);
        fire(edp_pkg::EVT_DBG_READ, 21'h0, edp_pkg::ACT_REFUSE, 6'h00);
        fire(edp_pkg::EVT_DBG_WRITE, 21'h0, edp_pkg::ACT_REFUSE, 6'h00);
        fire(edp_pkg::EVT_PAGE_ADD, c_enc, edp_pkg::ACT_FLAG_CLEAR, 6'h00);
        fire(edp_pkg::EVT_OP_SUPER, c_tmg, edp_pkg::ACT_NONE, 6'h03);
        fire(edp_pkg::EVT_OP_SUPER, c_tmg | c_flt, edp_pkg::ACT_NONE, 6'h01);
        fire(edp_pkg::EVT_REPORT, c_tmg | c_flt | c_vmx, edp_pkg::ACT_NONE, 6'h00);
        fire(edp_pkg::EVT_KEY_REQ, c_tmg, edp_pkg::ACT_NONE, 6'h03);
        fire(edp_pkg::EVT_REPORT, c_tmg | c_trm | c_mtm, edp_pkg::ACT_NONE, 6'h00);
        fire(edp_pkg::EVT_MC_FAULT, c_enc, edp_pkg::ACT_MC_EXIT, 6'h00);
        fire(edp_pkg::EVT_CORR_MC, c_enc, edp_pkg::ACT_MC_EXIT, 6'h00);
        wr(`EDP_OFS_CTRL, 32'h1);
        rd(`EDP_OFS_STATUS, 32'h4);
        reset_dut();
        wr(`EDP_OFS_CTRL, 32'h1);
        wr(`EDP_OFS_MCBANK, 32'hfe);
        wr(`EDP_OFS_MCBANK, 32'hff);
        rd(`EDP_OFS_STATUS, 32'h4);
        check({31'h0, cap}, 32'h0);
        end_of_test();
    end
endmodule
